//--- src/mbd_top.sv
// Program fetch counter and banked data memory decode
`timescale 1ns/1ns
module mbd_top #(
	parameter int GP_OFS_W = 7
) (
	input wire logic ref_clk,
	input wire logic rst,
	// Fetch side
	input wire logic fetch_en,
	input wire logic irq_take,
	input wire logic jump_en,
	input wire logic [mbd_pkg::PC_W-1:0] jump_addr,
	output logic [mbd_pkg::PC_W-1:0] pc,
	output logic [mbd_pkg::PROG_AW-1:0] prog_addr,
	output logic prog_rd,
	// Program store load port and fetched instruction word
	input wire logic prog_we,
	input wire logic [mbd_pkg::PROG_AW-1:0] prog_waddr,
	input wire logic [mbd_pkg::PROG_DW-1:0] prog_wdata,
	output logic [mbd_pkg::PROG_DW-1:0] instr,
	// Data side
	input wire logic data_rd,
	input wire logic data_wr,
	input wire logic use_pointer,
	input wire logic [mbd_pkg::OFS_W-1:0] data_ofs,
	input wire logic [mbd_pkg::DATA_W-1:0] data_wdata,
	output logic [mbd_pkg::DATA_W-1:0] data_rdata,
	output logic [mbd_pkg::DADDR_W-1:0] data_addr,
	output logic data_valid,
	output logic data_is_ctrl,
	output logic [mbd_pkg::DATA_W-1:0] status,
	output logic [mbd_pkg::DATA_W-1:0] indirect_pointer_register,
	output logic [1:0] bank_sel
);
	import mbd_pkg::*;

	// Program store, 2048 x 14
	logic [PROG_DW-1:0] prog_mem [0:(1<<PROG_AW)-1];
	// Mirrored control registers, one physical copy each
	logic [DATA_W-1:0] next_status;
	// Pointer holds the low eight bits of the nine-bit data address
	logic [DATA_W-1:0] next_pointer;
	// Counter high latch, kept for software only
	logic [DATA_W-1:0] pc_high;
	logic [DATA_W-1:0] next_pc_high;
	// Interrupt control byte, stored but not acted on here
	logic [DATA_W-1:0] intctl;
	logic [DATA_W-1:0] next_intctl;
	// Fetch state
	logic [PC_W-1:0] next_pc;
	logic next_prog_rd;
	logic [PROG_DW-1:0] next_instr;
	// Data decode results
	logic [DADDR_W-1:0] eff_addr;
	logic [1:0] eff_bank;
	logic [OFS_W-1:0] eff_ofs;
	logic eff_impl;
	logic eff_ctrl;
	logic [DATA_W-1:0] ram_q;
	logic ram_we;
	logic [DATA_W-1:0] next_rdata;
	logic next_valid;
	logic next_is_ctrl;
	logic [DADDR_W-1:0] next_daddr;

	// Program store write port, separate from the fetch path
	// Loading and fetching may share a cycle; the fetch sees the old word
	always_ff @(posedge ref_clk) begin
		if (prog_we) begin
			prog_mem[prog_waddr] <= prog_wdata;
		end
	end

	// Next fetch address: interrupt beats jump, jump beats increment
	always_comb begin
		next_pc = pc;
		next_prog_rd = 1'b0;
		next_instr = instr;
		// Vector wins, so an interrupt is never lost to a jump
		if (irq_take) begin
			next_pc = IRQ_VEC;
		end else if (jump_en) begin
			// Jump target taken as given, upper bits included
			next_pc = jump_addr;
		end else if (fetch_en) begin
			// Full 13 bits count; the store sees only the low 11
			next_pc = pc + 13'h0001;
		end
		if (fetch_en) begin
			// Upper counter bits ignored, so high addresses wrap
			next_instr = prog_mem[pc[PROG_AW-1:0]];
			next_prog_rd = 1'b1;
		end
	end

	// Fetch registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			// Reset parks the counter on the reset vector
			pc <= RESET_VEC;
			prog_addr <= '0;
			prog_rd <= 1'b0;
			instr <= '0;
		end else begin
			// Store address follows the wrapped counter
			pc <= next_pc;
			prog_addr <= next_pc[PROG_AW-1:0];
			prog_rd <= next_prog_rd;
			instr <= next_instr;
		end
	end

	// Address formation, direct or through the pointer
	always_comb begin
		if (use_pointer) begin
			// Pointer gives offset and low bank bit; high bit stays as set
			eff_addr = {status[STAT_BSH], indirect_pointer_register};
		end else begin
			eff_addr = {status[STAT_BSH], status[STAT_BSL], data_ofs};
		end
		// Top two address bits name the bank
		eff_bank = eff_addr[DADDR_W-1:OFS_W];
		eff_ofs = eff_addr[OFS_W-1:0];
		// Banks two and three do not exist here
		eff_impl = (eff_bank == MBD_BANK0) || (eff_bank == MBD_BANK1);
		// Offsets below the general purpose base are control slots
		eff_ctrl = eff_ofs < OFS_GP_BASE;
	end

	// General purpose RAM, one array per implemented bank pair
	// Bank bit zero picks the half; banks two and three never write
	// A read in the cycle of a write still sees the old byte
	assign ram_we = data_wr && eff_impl && !eff_ctrl;
	mbd_ram #(
		.AW(GP_OFS_W + 1),
		.DW(DATA_W)
	) u_gp_ram (
		.clk(ref_clk),
		.we(ram_we),
		.waddr({eff_bank[0], eff_ofs}),
		.wdata(data_wdata),
		.raddr({eff_bank[0], eff_ofs}),
		.rdata(ram_q)
	);

	// Register writes and read mux; data path runs beside fetch each cycle
	always_comb begin
		// Defaults hold every register; valid is a one-cycle pulse
		next_status = status;
		next_pointer = indirect_pointer_register;
		next_pc_high = pc_high;
		next_intctl = intctl;
		next_rdata = data_rdata;
		next_valid = 1'b0;
		next_is_ctrl = data_is_ctrl;
		next_daddr = data_addr;
		// Mirrored: same offset hits one copy in both banks
		// Writes to unimplemented banks fall through untouched
		if (data_wr && eff_impl && eff_ctrl) begin
			unique case (eff_ofs)
				OFS_STATUS: next_status = data_wdata;
				OFS_POINTER: next_pointer = data_wdata;
				OFS_PCHIGH: next_pc_high = data_wdata;
				OFS_INTCTL: next_intctl = data_wdata;
				// Indirect, counter low and peripheral slots ignore writes
				default: next_status = status;
			endcase
		end
		// Address and decode latched on any access, beside any fetch
		if (data_rd || data_wr) begin
			next_valid = 1'b1;
			next_is_ctrl = eff_ctrl;
			next_daddr = eff_addr;
		end
		// Read mux: missing banks, control slots, then RAM
		if (data_rd) begin
			if (!eff_impl) begin
				// Unimplemented banks read as zero
				next_rdata = ZERO_BYTE;
			end else if (eff_ctrl) begin
				// Control slots read the shared copy in either bank
				unique case (eff_ofs)
					OFS_PCLOW: next_rdata = pc[DATA_W-1:0];
					OFS_STATUS: next_rdata = status;
					OFS_POINTER: next_rdata = indirect_pointer_register;
					OFS_PCHIGH: next_rdata = pc_high;
					OFS_INTCTL: next_rdata = intctl;
					// Indirect slot and peripheral slots read zero here
					default: next_rdata = ZERO_BYTE;
				endcase
			end else begin
				// General purpose bytes above the control block
				next_rdata = ram_q;
			end
		end
	end

	// Data side registers
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			// Status as after power up; every other register zero
			status <= STATUS_RST;
			indirect_pointer_register <= ZERO_BYTE;
			pc_high <= ZERO_BYTE;
			intctl <= ZERO_BYTE;
			data_rdata <= ZERO_BYTE;
			data_valid <= 1'b0;
			data_is_ctrl <= 1'b0;
			data_addr <= '0;
			bank_sel <= 2'b00;
		end else begin
			status <= next_status;
			indirect_pointer_register <= next_pointer;
			pc_high <= next_pc_high;
			intctl <= next_intctl;
			data_rdata <= next_rdata;
			data_valid <= next_valid;
			data_is_ctrl <= next_is_ctrl;
			data_addr <= next_daddr;
			// Copy of the next status, so both change on one edge
			bank_sel <= next_status[STAT_BSH:STAT_BSL];
		end
	end
endmodule // mbd_top

//--- src/mbd_pkg.sv
// Constants shared by the memory map and bank decode block
// How it works
// - Separate program and data buses, same cycle
// - Thirteen-bit counter, 2048 words of fourteen bits
// - Fetch addresses above 0x7FF wrap around
// - Fetch starts at address zero after reset
// - Interrupt redirects fetch to address four
// - Status bits six, five select data bank
// - Each bank decodes 128 byte offsets
// - Low offsets are control registers, rest RAM
// - Mirrored registers share one physical copy
// - Data addressed directly or via pointer
package mbd_pkg;
	localparam int PC_W = 13;
	localparam int PROG_AW = 11;
	localparam int PROG_DW = 14;
	localparam int DATA_W = 8;
	localparam int OFS_W = 7;
	localparam int DADDR_W = 9;
	localparam logic [PC_W-1:0] RESET_VEC = 13'h0000;
	localparam logic [PC_W-1:0] IRQ_VEC = 13'h0004;
	localparam int STAT_BSL = 5;
	localparam int STAT_BSH = 6;
	localparam logic [OFS_W-1:0] OFS_INDIRECT = 7'h00;
	localparam logic [OFS_W-1:0] OFS_PCLOW = 7'h02;
	localparam logic [OFS_W-1:0] OFS_STATUS = 7'h03;
	localparam logic [OFS_W-1:0] OFS_POINTER = 7'h04;
	localparam logic [OFS_W-1:0] OFS_PCHIGH = 7'h0A;
	localparam logic [OFS_W-1:0] OFS_INTCTL = 7'h0B;
	localparam logic [OFS_W-1:0] OFS_GP_BASE = 7'h20;
	localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
	localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;
	typedef enum logic [1:0] {
		MBD_BANK0 = 2'b00,
		MBD_BANK1 = 2'b01,
		MBD_BANK2 = 2'b10,
		MBD_BANK3 = 2'b11
	} mbd_bank_t;
endpackage

//--- src/mbd_ram.sv
// Simple synchronous-write byte store with combinational read
`timescale 1ns/1ns
module mbd_ram #(
	parameter int AW = 7,
	parameter int DW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	// Storage array, no reset: RAM contents are undefined at power up
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// Asynchronous read port
	assign rdata = mem[raddr];
endmodule // mbd_ram

//--- tb/mbd_core.sv
// Core-side model issuing fetch, load and data requests
`timescale 1ns/1ns
module mbd_core (
	input wire logic ref_clk,
	output logic fetch_en = 1'b0,
	output logic irq_take = 1'b0,
	output logic jump_en = 1'b0,
	output logic [12:0] jump_addr = 13'h0000,
	output logic prog_we = 1'b0,
	output logic [10:0] prog_waddr = 11'h000,
	output logic [13:0] prog_wdata = 14'h0000,
	output logic data_rd = 1'b0,
	output logic data_wr = 1'b0,
	output logic use_pointer = 1'b0,
	output logic [6:0] data_ofs = 7'h00,
	output logic [7:0] data_wdata = 8'h00
);
	// One request cycle; caller enters just after an edge
	// Lines stay up until the next call or idle, so none is set twice in a step
	task automatic op(input logic f, i, j, r, w, p, input logic [12:0] a, input logic [13:0] d);
		prog_we = 1'b0;
		{fetch_en, irq_take, jump_en, data_rd, data_wr, use_pointer} = {f, i, j, r, w, p};
		jump_addr = a;
		data_ofs = a[6:0];
		data_wdata = d[7:0];
		@(posedge ref_clk);
		#1;
	endtask
	// Program store load, one word
	task automatic load(input logic [10:0] a, input logic [13:0] d);
		{fetch_en, irq_take, jump_en, data_rd, data_wr, use_pointer} = 6'h00;
		{prog_we, prog_waddr, prog_wdata} = {1'b1, a, d};
		@(posedge ref_clk);
		#1;
	endtask
	// Release every request for one cycle
	task automatic idle;
		prog_we = 1'b0;
		{fetch_en, irq_take, jump_en, data_rd, data_wr, use_pointer} = 6'h00;
		// Released lines flip so stale values are never mistaken for live ones
		jump_addr = ~jump_addr;
		data_ofs = ~data_ofs;
		data_wdata = ~data_wdata;
		@(posedge ref_clk);
		#1;
	endtask
endmodule // mbd_core

//--- tb/mbd_props.sv
// Checker for fetch counter and data decode
`timescale 1ns/1ns
module mbd_props (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic fetch_en,
	input wire logic irq_take,
	input wire logic jump_en,
	input wire logic [12:0] pc,
	input wire logic prog_rd,
	input wire logic data_rd,
	input wire logic data_wr,
	input wire logic use_pointer,
	input wire logic [6:0] data_ofs,
	input wire logic [7:0] data_wdata,
	input wire logic [8:0] data_addr,
	input wire logic data_valid,
	input wire logic data_is_ctrl,
	input wire logic [7:0] status,
	input wire logic [7:0] indirect_pointer_register,
	input wire logic [1:0] bank_sel
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire acc = data_rd | data_wr;
	pc_reset_a: assert property ($fell(rst) |-> pc == 13'h0000)
		else $error("pc not zero");
	irq_vec_a: assert property (irq_take |=> pc == 13'h0004)
		else $error("irq vector");
	pc_inc_a: assert property (fetch_en && !irq_take && !jump_en
		|=> prog_rd && pc == $past(pc) + 13'h1) else $error("pc step");
	bank_sel_a: assert property (bank_sel == status[6:5])
		else $error("bank select");
	bank_wr_a: assert property (data_wr && !use_pointer && data_ofs == 7'h03 && !status[6]
		|=> bank_sel == $past(data_wdata[6:5])) else $error("bank write");
	dir_addr_a: assert property (acc && !use_pointer
		|=> data_addr == {$past(status[6:5]), $past(data_ofs)}) else $error("direct addr");
	ind_addr_a: assert property (acc && use_pointer
		|=> data_addr == {$past(status[6]), $past(indirect_pointer_register)})
		else $error("pointer addr");
	data_valid_a: assert property (data_valid == $past(acc))
		else $error("valid timing");
	ctrl_map_a: assert property (acc && !use_pointer
		|=> data_is_ctrl == ($past(data_ofs) < 7'h20)) else $error("ctrl decode");
endmodule // mbd_props

//--- tb/memory_map_and_bank_decode_tb.sv
// Self-checking bench for the memory map and bank decode block
`timescale 1ns/1ns
module memory_map_and_bank_decode_tb;
	import mbd_pkg::*;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic fetch_en, irq_take, jump_en, prog_we, data_rd, data_wr, use_pointer;
	logic prog_rd, data_valid, data_is_ctrl;
	logic [PC_W-1:0] jump_addr, pc;
	logic [PROG_AW-1:0] prog_addr, prog_waddr;
	logic [PROG_DW-1:0] prog_wdata, instr;
	logic [OFS_W-1:0] data_ofs;
	logic [DATA_W-1:0] data_wdata, data_rdata, status, indirect_pointer_register;
	logic [DADDR_W-1:0] data_addr;
	logic [1:0] bank_sel;
	int miscompares = 0;
	int comparisons = 0;
	// 125 MHz clock
	always #4 ref_clk = ~ref_clk;
	mbd_top dut (.*);
	mbd_core core (.*);
	// Value compare, widened to the largest result
	task automatic chk(input string n, input logic [13:0] s, input logic [13:0] e);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic report_and_stop;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// Fetch from zero, top word, wrap and vector
	task automatic t_fetch;
		core.load(11'h000, 14'h1A5C);
		core.load(11'h7FF, 14'h2B3D);
		core.op(1, 0, 0, 0, 0, 0, 0, 0);
		chk("instr", instr, 14'h1A5C);
		chk("pc", pc, 13'h0001);
		core.op(0, 0, 1, 0, 0, 0, 13'h07FF, 0);
		core.op(1, 0, 0, 0, 0, 0, 0, 0);
		chk("instr", instr, 14'h2B3D);
		chk("prog_addr", prog_addr, 11'h000);
		core.op(1, 0, 0, 0, 0, 0, 0, 0);
		chk("instr", instr, 14'h1A5C);
		chk("pc", pc, 13'h0801);
		chk("prog_addr", prog_addr, 11'h001);
		core.op(1, 1, 0, 0, 0, 0, 0, 0);
		chk("pc", pc, IRQ_VEC);
		core.idle();
		chk("pc", pc, IRQ_VEC);
	endtask
	// Bank switching, mirrors, both RAM banks, pointer access
	task automatic t_bank;
		core.op(0, 0, 0, 0, 1, 0, OFS_STATUS, 8'h20);
		chk("bank_sel", bank_sel, 2'b01);
		chk("valid", data_valid, 1'b1);
		core.op(0, 0, 0, 0, 1, 0, 7'h20, 8'hA5);
		core.op(0, 0, 0, 0, 1, 0, 7'h7F, 8'h3C);
		core.op(0, 0, 0, 1, 0, 0, 7'h7F, 0);
		chk("rdata", data_rdata, 8'h3C);
		core.op(0, 0, 0, 1, 0, 0, OFS_STATUS, 0);
		chk("rdata", data_rdata[6:5], 2'b01);
		core.op(0, 0, 0, 0, 1, 0, OFS_STATUS, 8'h00);
		chk("bank_sel", bank_sel, 2'b00);
		core.op(0, 0, 0, 0, 1, 0, 7'h20, 8'h5A);
		core.op(1, 0, 0, 1, 0, 0, 7'h20, 0);
		chk("rdata", data_rdata, 8'h5A);
		chk("prog_rd", prog_rd, 1'b1);
		chk("addr", data_addr, 9'h020);
		chk("ctrl", data_is_ctrl, 1'b0);
		core.op(0, 0, 0, 0, 1, 0, OFS_POINTER, 8'hA0);
		chk("pointer", indirect_pointer_register, 8'hA0);
		core.op(0, 0, 0, 1, 0, 1, 0, 0);
		chk("rdata", data_rdata, 8'hA5);
		chk("addr", data_addr, 9'h0A0);
		core.op(0, 0, 0, 1, 0, 0, 7'h1F, 0);
		chk("ctrl", data_is_ctrl, 1'b1);
		chk("rdata", data_rdata, 8'h00);
	endtask
	// Unimplemented bank refused, then a reset in mid-run
	task automatic t_reset;
		// Bank two on purpose, only to see it refused
		core.op(0, 0, 0, 0, 1, 0, OFS_STATUS, 8'h40);
		chk("bank_sel", bank_sel, 2'b10);
		core.op(0, 0, 0, 0, 1, 0, 7'h20, 8'h77);
		core.op(0, 0, 0, 1, 0, 0, 7'h20, 0);
		chk("rdata", data_rdata, 8'h00);
		core.op(0, 0, 0, 0, 1, 0, OFS_STATUS, 8'h00);
		chk("bank_sel", bank_sel, 2'b10);
		core.idle();
		rst = 1'b1;
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b0;
		chk("pc", pc, RESET_VEC);
		chk("status", status, STATUS_RST);
		chk("bank_sel", bank_sel, 2'b00);
		chk("valid", data_valid, 1'b0);
		core.op(1, 0, 0, 0, 0, 0, 0, 0);
		chk("instr", instr, 14'h1A5C);
		// Bank zero byte must not have taken the refused write
		core.op(0, 0, 0, 1, 0, 0, 7'h20, 0);
		chk("rdata", data_rdata, 8'h5A);
		core.idle();
	endtask
	// Main sequence
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 rst = 1'b0;
		t_fetch();
		t_bank();
		t_reset();
		report_and_stop();
	end
	// Watchdog well beyond the forty-nine cycles the tests need
	initial begin
		repeat (2000) @(posedge ref_clk);
		miscompares++;
		report_and_stop();
	end
endmodule // memory_map_and_bank_decode_tb
bind mbd_top mbd_props props (.*);
